/* File: rtl/serial_nv_memory_slave.sv */
// two-wire serial slave in front of a 2048-byte memory array, plus write fifo
// assumes scl, sda_in and wp come from pins asynchronous to clk
//
// Contract
// - slave only, never drives clock
// - sample on rise, change after fall
// - data line only pulled low or released
// - protect input high blocks all writes
// - 2048 bytes, row plus segment address
// - received byte committed right after transfer
// - never busy, no polling needed
// - only power-on reset initialises state
// - low-to-high data with clock high is stop
// - stop aborts pending operation to idle
// - high-to-low data with clock high is start
// - start abandons operation, expect address
// - data stable while clock high
// - ninth clock carries acknowledge
// - released acknowledge ends the operation
// - read continues while master acknowledges
// - address byte: type, page, direction
// - word byte plus page forms address
// - address increments per byte, wraps
// - protected writes unacked, address held
`timescale 1ns/100ps
`default_nettype none
`include "nv_slave_consts.svh"

// ----------------------------------------
// write fifo
// ----------------------------------------
module nv_byte_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,       // system clock
  input  wire logic             reset,     // async reset, high
  input  wire logic             in_valid,  // push request
  output logic                  in_ready,  // room left
  input  wire logic [WIDTH-1:0] in_data,   // pushed word
  output logic                  out_valid, // word waiting
  input  wire logic             out_ready, // drain accepts
  output logic      [WIDTH-1:0] out_data   // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];          // storage
  logic [AW:0]      wr_ptr;               // write pointer
  logic [AW:0]      rd_ptr;               // read pointer
  logic             do_push;              // push this cycle
  logic             do_pop;               // pop this cycle

  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // pointer update
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // storage write
  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule : nv_byte_fifo

// ----------------------------------------
// slave top
// ----------------------------------------
module serial_nv_memory_slave #(
  parameter logic [3:0] TYPE_CODE = `NVS_TYPE_CODE, // arbitrary device-type value
  parameter int         DEPTH     = `NVS_DEPTH,
  parameter int         FIFO_D    = `NVS_FIFO_DEPTH
) (
  input  wire logic clk,        // system clock, 100 MHz
  input  wire logic reset,      // power-on reset, async high
  input  wire logic scl,        // bus clock pin, input only
  input  wire logic sda_in,     // bus data pin level
  output logic      sda_out,    // bus data drive value, always 0
  output logic      sda_oe,     // high pulls data low
  input  wire logic wp          // write protect pin
);
  localparam int AW = `NVS_ADDR_W;
  localparam int FW = AW + 8;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [2:0]           scl_s;    // scl synchroniser
    logic [2:0]           sda_s;    // sda synchroniser
    logic [2:0]           wp_s;     // wp synchroniser
    logic                 scl_q;    // filtered scl
    logic                 sda_q;    // filtered sda
    logic                 wp_q;     // filtered wp
    nv_slave_pkg::phase_e phase;    // protocol phase
    logic [3:0]           bitcnt;   // bits of current byte
    logic [7:0]           shreg;    // shift register
    logic [AW-1:0]        addr;     // address latch
    logic                 rd;       // read transaction
    logic                 ack_drv;  // drive ack low
    logic                 dat_drv;  // drive read bit low
    logic                 push;     // write to fifo
    logic [FW-1:0]        push_w;   // address and data
    logic [7:0]           rdata;    // fetched read byte
  } state_s;

  state_s st;                       // registered state
  state_s next_st;                  // next state
  logic [7:0]   mem [DEPTH];        // the array
  logic         f_ready;            // fifo room
  logic         f_valid;            // fifo holds write
  logic [FW-1:0] f_data;            // fifo head

  // ----------------------------------------
  // write path
  // ----------------------------------------
  nv_byte_fifo #(.WIDTH(FW), .DEPTH(FIFO_D)) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (st.push),
    .in_ready  (f_ready),
    .in_data   (st.push_w),
    .out_valid (f_valid),
    .out_ready (1'b1),
    .out_data  (f_data)
  );

  // array commit within cycles of the byte, far under one bus clock
  always_ff @(posedge clk)
  begin
    if (f_valid)
      mem[f_data[FW-1:8]] <= f_data[7:0];
  end

  // ----------------------------------------
  // protocol
  // ----------------------------------------
  always_comb
  begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [7:0] nb;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c  = 1'b0;
    stop_c   = 1'b0;
    nb       = '0;
    next_st       = st;
    next_st.push  = 1'b0;
    next_st.scl_s = {st.scl_s[1:0], scl};
    next_st.sda_s = {st.sda_s[1:0], sda_in};
    next_st.wp_s  = {st.wp_s[1:0], wp};
    // a change counts once stages two and three agree
    if (st.scl_s[2] == st.scl_s[1])
      next_st.scl_q = st.scl_s[1];
    if (st.sda_s[2] == st.sda_s[1])
      next_st.sda_q = st.sda_s[1];
    if (st.wp_s[2] == st.wp_s[1])
      next_st.wp_q = st.wp_s[1];
    scl_rise = next_st.scl_q && !st.scl_q;
    scl_fall = !next_st.scl_q && st.scl_q;
    start_c  = st.scl_q && next_st.scl_q && st.sda_q && !next_st.sda_q;
    stop_c   = st.scl_q && next_st.scl_q && !st.sda_q && next_st.sda_q;
    nb       = {st.shreg[6:0], st.sda_q};
    if (start_c)
    begin
      // abandon whatever was going on
      next_st.phase   = nv_slave_pkg::ST_DEVID;
      next_st.bitcnt  = '0;
      next_st.ack_drv = 1'b0;
      next_st.dat_drv = 1'b0;
    end
    else if (stop_c)
    begin
      next_st.phase   = nv_slave_pkg::ST_IDLE;
      next_st.ack_drv = 1'b0;
      next_st.dat_drv = 1'b0;
    end
    else if (scl_rise)
    begin
      // sample on the rising edge
      case (st.phase)
        nv_slave_pkg::ST_DEVID, nv_slave_pkg::ST_WORD, nv_slave_pkg::ST_WRITE:
        begin
          next_st.shreg  = nb;
          next_st.bitcnt = st.bitcnt + 4'h1;
        end
        nv_slave_pkg::ST_READ:
          next_st.bitcnt = st.bitcnt + 4'h1;
        nv_slave_pkg::ST_RACK:
        begin
          // released acknowledge ends the read
          if (st.sda_q)
            next_st.phase = nv_slave_pkg::ST_IGN;
          else
            next_st.rdata = mem[st.addr];
        end
        default:
          next_st.phase = st.phase;
      endcase
    end
    else if (scl_fall)
    begin
      // outgoing bits change only after the falling edge
      next_st.ack_drv = 1'b0;
      case (st.phase)
        nv_slave_pkg::ST_DEVID:
        begin
          if (st.bitcnt == 4'h8)
          begin
            next_st.bitcnt = '0;
            if (st.shreg[`NVS_TYPE_HI:`NVS_TYPE_LO] == TYPE_CODE)
            begin
              next_st.ack_drv = 1'b1;
              next_st.rd      = st.shreg[`NVS_DIR_BIT];
              next_st.addr    = {st.shreg[`NVS_PAGE_HI:`NVS_PAGE_LO], st.addr[7:0]};
              next_st.phase   = nv_slave_pkg::ST_ACK;
            end
            else
              next_st.phase = nv_slave_pkg::ST_IGN;
          end
        end
        nv_slave_pkg::ST_ACK:
        begin
          // ninth clock done, pick the data phase
          next_st.bitcnt = '0; // every data byte counts from zero
          if (st.rd)
          begin
            next_st.phase   = nv_slave_pkg::ST_READ;
            next_st.shreg   = mem[st.addr];
            next_st.dat_drv = !mem[st.addr][7];
          end
          else if (st.ack_drv && st.bitcnt == 4'h0)
            next_st.phase = nv_slave_pkg::ST_WORD;
          else
            next_st.phase = nv_slave_pkg::ST_WRITE;
        end
        nv_slave_pkg::ST_WORD:
        begin
          if (st.bitcnt == 4'h8)
          begin
            next_st.addr    = {st.addr[AW-1:8], st.shreg};
            next_st.ack_drv = 1'b1;
            next_st.phase   = nv_slave_pkg::ST_ACK;
            next_st.bitcnt  = 4'h1;
          end
        end
        nv_slave_pkg::ST_WRITE:
        begin
          if (st.bitcnt == 4'h8)
          begin
            next_st.bitcnt = '0;
            if (!st.wp_q && f_ready)
            begin
              next_st.push    = 1'b1;
              next_st.push_w  = {st.addr, st.shreg};
              next_st.addr    = st.addr + 1'b1;
              next_st.ack_drv = 1'b1;
              next_st.phase   = nv_slave_pkg::ST_ACK;
              next_st.bitcnt  = 4'h1;
            end
            else
              next_st.phase = nv_slave_pkg::ST_IGN;
          end
        end
        nv_slave_pkg::ST_READ:
        begin
          if (st.bitcnt == 4'h8)
          begin
            // release for the master's acknowledge
            next_st.bitcnt  = '0;
            next_st.dat_drv = 1'b0;
            next_st.addr    = st.addr + 1'b1;
            next_st.phase   = nv_slave_pkg::ST_RACK;
          end
          else
          begin
            next_st.shreg   = {st.shreg[6:0], 1'b0};
            next_st.dat_drv = !st.shreg[6];
          end
        end
        nv_slave_pkg::ST_RACK:
        begin
          // master acknowledged, next byte out
          next_st.phase   = nv_slave_pkg::ST_READ;
          next_st.shreg   = st.rdata;
          next_st.dat_drv = !st.rdata[7];
        end
        default:
          next_st.phase = st.phase;
      endcase
    end
  end

  // state register; power-on reset is the only initialiser
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st       <= '0;
      st.scl_s <= 3'h0; // bus clock idles low
      st.sda_s <= 3'h7;
      st.scl_q <= 1'b0; // no false edge after reset
      st.sda_q <= 1'b1;
      st.addr  <= `NVS_ADDR_RST;
      st.phase <= nv_slave_pkg::ST_IDLE;
    end
    else
      st <= next_st;
  end

  // open-drain: only ever pulls low; scl is never driven
  assign sda_out = 1'b0;
  assign sda_oe  = st.ack_drv || st.dat_drv;
endmodule : serial_nv_memory_slave
`default_nettype wire

/* File: rtl/nv_slave_consts.svh */
// size, field and reset constants for the two-wire memory slave
// assumes inclusion by bare name from rtl files
`ifndef NV_SLAVE_CONSTS_SVH
`define NV_SLAVE_CONSTS_SVH
`define NVS_ADDR_W      11
`define NVS_DEPTH       2048
`define NVS_TYPE_HI     7
`define NVS_TYPE_LO     4
`define NVS_PAGE_HI     3
`define NVS_PAGE_LO     1
`define NVS_DIR_BIT     0
`define NVS_TYPE_CODE   4'h5
`define NVS_ADDR_RST    11'h000
`define NVS_FIFO_DEPTH  16
`endif

/* File: rtl/nv_slave_pkg.sv */
// types for the two-wire memory slave
// assumes nothing of its surroundings
package nv_slave_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'h0,
    ST_DEVID = 3'h1,
    ST_ACK   = 3'h3,
    ST_WORD  = 3'h2,
    ST_WRITE = 3'h6,
    ST_READ  = 3'h7,
    ST_RACK  = 3'h5,
    ST_IGN   = 3'h4
  } phase_e;
endpackage : nv_slave_pkg

/* File: verification/nv_slave_checker.sv */
// pin-level assertions for the two-wire memory slave
// assumes binding to serial_nv_memory_slave, data wire pulled up
`timescale 1ns/100ps
`default_nettype none
module nv_slave_checker (
  input  wire logic clk,     // system clock
  input  wire logic reset,   // async reset, high
  input  wire logic scl,     // bus clock pin
  input  wire logic sda_in,  // data wire level
  input  wire logic sda_out, // drive value
  input  wire logic sda_oe,  // pull-low enable
  input  wire logic wp       // write protect
);
  logic       scl_q;      // last clock level
  logic       sda_q;      // last data level
  logic       seen_start; // a start since reset
  logic [7:0] oe_run;     // cycles driven in a row
  logic       start_ev;   // data fell, clock high
  logic       stop_ev;    // data rose, clock high
  assign start_ev = scl & scl_q & sda_q & ~sda_in;
  assign stop_ev  = scl & scl_q & ~sda_q & sda_in;
  // ----------------------------------------
  // bus condition tracking
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scl_q      <= 1'b0;
      sda_q      <= 1'b1;
      seen_start <= 1'b0;
      oe_run     <= 8'h00;
    end
    else
    begin
      scl_q      <= scl;
      sda_q      <= sda_in;
      seen_start <= seen_start | start_ev;
      oe_run     <= sda_oe ? ((oe_run == 8'hFF) ? oe_run : oe_run + 8'h01) : 8'h00;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence start_seen; start_ev; endsequence
  sequence stop_seen; stop_ev; endsequence
  sequence idle8; !sda_oe [*8]; endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_OPEN_DRAIN: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("data driven high");
  AST_RESET_RELEASE: assert property ($fell(reset) |-> !sda_oe [*3])
    else $error("drive right after reset");
  AST_NO_DRIVE_BEFORE_START: assert property (!seen_start |-> !sda_oe)
    else $error("drive before any start");
  AST_CHANGE_IN_LOW: assert property ($changed(sda_oe) |-> !scl)
    else $error("drive changed with clock high");
  AST_STOP_IDLE: assert property (stop_seen |=> idle8)
    else $error("drive after stop");
  AST_START_RELEASE: assert property (start_seen |=> idle8)
    else $error("drive after start");
  AST_DRIVE_HOLD: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("drive pulse too short");
  AST_DRIVE_BOUNDED: assert property (oe_run <= 8'h96)
    else $error("drive held too long");
endmodule : nv_slave_checker
bind serial_nv_memory_slave nv_slave_checker u_nv_slave_checker (
  .clk(clk), .reset(reset), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp));
`default_nettype wire

/* File: verification/bus_master_model.sv */
// two-wire bus master model, owns the bus clock
// assumes a pulled-up data wire resolved by the bench
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
  input  wire logic clk,   // bench clock
  input  wire logic sda,   // resolved data wire
  output logic      scl,   // bus clock
  output logic      sda_m  // 0 pulls wire low
);
  initial
  begin
    scl   = 1'b0; // idle low
    sda_m = 1'b1; // released
  end
  // ----------------------------------------
  // bus conditions and bits
  // ----------------------------------------
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask : gap
  task automatic start_c();
    sda_m = 1'b1;
    gap(8);
    scl = 1'b1;
    gap(8);
    sda_m = 1'b0;
    gap(8);
    scl = 1'b0;
  endtask : start_c
  task automatic stop_c();
    gap(4);
    sda_m = 1'b0;
    gap(4);
    scl = 1'b1;
    gap(8);
    sda_m = 1'b1;
    gap(8);
    scl = 1'b0;
  endtask : stop_c
  task automatic bit_x(input logic d, output logic s);
    gap(4);
    sda_m = d; // change only while low
    gap(4);
    scl = 1'b1;
    gap(8);
    s = sda;   // late in high phase
    scl = 1'b0;
  endtask : bit_x
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(tx[i], s); // msb first
      rx[i] = s;
    end
    bit_x(!ack_in, s); // ninth clock
    ack_out = !s;
  endtask : xfer
endmodule : bus_master_model
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the two-wire memory slave
// assumes the master model and checker are compiled alongside
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [3:0] DEV_TYPE = 4'h5; // arbitrary type value
  logic        clk;          // system clock
  logic        reset;        // power-on reset
  logic        wp;           // write protect
  logic        scl;          // from master
  logic        sda_m;        // master drive
  logic        sda_out;      // slave drive value
  logic        sda_oe;       // slave pulls low
  logic        sda;          // resolved wire
  logic [7:0]  mem [0:2047]; // expected array
  logic [10:0] adr;          // expected latch
  logic [2:0]  pg;           // random page
  logic [7:0]  wd;           // random word
  logic        ab;           // spare bit sample
  int          n;            // byte count
  int          err_total;    // mismatches
  int          checked;      // comparisons
  assign sda = sda_m & (sda_oe ? sda_out : 1'b1); // pull-up wire
  initial clk = 1'b0;
  always #5 clk = ~clk;
  serial_nv_memory_slave #(.TYPE_CODE(DEV_TYPE)) u_serial_nv_memory_slave (
    .clk(clk), .reset(reset), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp));
  bus_master_model u_bus_master_model (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  // ----------------------------------------
  // checks and transactions
  // ----------------------------------------
  task automatic finish_test();
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic put(input logic [7:0] b, input logic exp_ack);
    logic [7:0] r;
    logic       a;
    u_bus_master_model.xfer(b, 1'b0, r, a);
    chk(a === exp_ack, "acknowledge");
  endtask : put
  task automatic wr_txn(input logic [2:0] p, input logic [7:0] w, input int k);
    logic [7:0] d;
    u_bus_master_model.start_c();
    put({DEV_TYPE, p, 1'b0}, 1'b1);
    put(w, 1'b1);
    adr = {p, w};
    repeat (k)
    begin
      d = 8'($urandom);
      put(d, !wp);
      if (!wp)
      begin
        mem[adr] = d;
        adr = adr + 11'h001;
      end
    end
  endtask : wr_txn
  task automatic rd_txn(input logic [2:0] p, input int k);
    logic [7:0] r;
    logic       a;
    u_bus_master_model.start_c();
    put({DEV_TYPE, p, 1'b1}, 1'b1);
    adr[10:8] = p;
    for (int i = 0; i < k; i++)
    begin
      u_bus_master_model.xfer(8'hFF, i < k - 1, r, a);
      chk(r === mem[adr] && !$isunknown(r), "read data");
      adr = adr + 11'h001;
    end
    u_bus_master_model.stop_c();
  endtask : rd_txn
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h178A));
    err_total = 0;
    checked = 0;
    wp = 1'b0;
    adr = 11'h000;
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    u_bus_master_model.start_c();
    put({DEV_TYPE ^ 4'h3, 3'h2, 1'b0}, 1'b0);
    put(8'h5A, 1'b0);
    u_bus_master_model.stop_c();
    wr_txn(3'h7, 8'hFE, 4);
    u_bus_master_model.stop_c();
    wr_txn(3'h7, 8'hFE, 0);
    rd_txn(3'h7, 4);
    wp = 1'b1;
    wr_txn(3'h7, 8'hFE, 2);
    u_bus_master_model.stop_c();
    wp = 1'b0;
    rd_txn(3'h7, 1);
    wr_txn(3'h7, 8'hFE, 0);
    repeat (4) u_bus_master_model.bit_x(1'b0, ab);
    u_bus_master_model.stop_c();
    wr_txn(3'h7, 8'hFE, 0);
    rd_txn(3'h7, 1);
    repeat (6)
    begin
      pg = 3'($urandom);
      wd = 8'($urandom);
      n = $urandom_range(1, 4);
      wr_txn(pg, wd, n);
      u_bus_master_model.stop_c();
      wr_txn(pg, wd, 0);
      rd_txn(pg, n);
    end
    finish_test();
  end
  // hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
